// file: rtl/sdram_pin_regs.vh
/*
 contents: constants for the sdram command pin block (region decode, command codes, timing).
 assumes: included by bare name from the rtl files.
*/
`ifndef SDRAM_PIN_REGS_VH
`define SDRAM_PIN_REGS_VH

// sdram region: address bits 31:30
`define REGION_HI 31
`define REGION_LO 30
`define REGION_SDRAM 2'h1
// bank select field: address bits 29:28
`define BANK_HI 29
`define BANK_LO 28

// request command codes
`define CMD_READ 3'h0
`define CMD_WRITE 3'h1
`define CMD_ACTIVE 3'h2
`define CMD_PRECHARGE 3'h3
`define CMD_REFRESH 3'h4
`define CMD_MODE 3'h5
`define CMD_SELF_REFRESH 3'h6
`define CMD_POWER_DOWN 3'h7

// pin codes {ras, cas, we}, active low
`define PINS_NOP 3'h7
`define PINS_ACTIVE 3'h3
`define PINS_READ 3'h5
`define PINS_WRITE 3'h4
`define PINS_PRECHARGE 3'h2
`define PINS_REFRESH 3'h1
`define PINS_MODE 3'h0

// clock rate and exit time from low power
`define CLK_MHZ 25
`define LP_EXIT_NS 80
`define LP_EXIT_CYC ((`LP_EXIT_NS * `CLK_MHZ + 999) / 1000)

`endif

// file: rtl/pin_sync.v
/*
 contents: two-flop synchroniser, one bit per lane.
 assumes: asynchronous inputs, single clock.
*/
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// lanes
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : lane
			// first stage feeds only the second
			always @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					meta_reg[i] <= 1'b0;
					sync_reg[i] <= 1'b0;
				end else begin
					meta_reg[i] <= async_in[i];
					sync_reg[i] <= meta_reg[i];
				end
			end
		end
	endgenerate
	assign sync_out = sync_reg;
endmodule // pin_sync

// file: rtl/bank_decode.v
/*
 contents: region check and one-hot bank select decode of an address.
 assumes: reserved spaces are flagged by the caller.
*/
`timescale 1ns/1ps
`include "sdram_pin_regs.vh"
module bank_decode (
	// address in
	input wire [31:0] addr,
	input wire reserved,
	// decode out
	output wire in_region,
	output wire [3:0] bank_onehot
);
	function [3:0] onehot4;
		input [1:0] sel;
		begin
			onehot4 = 4'h1 << sel;
		end
	endfunction
	assign in_region = (addr[`REGION_HI:`REGION_LO] == `REGION_SDRAM) && !reserved;
	assign bank_onehot = in_region ? onehot4(addr[`BANK_HI:`BANK_LO]) : 4'h0;
endmodule // bank_decode

// file: rtl/sdram_command_pins.v
/*
 contents: pin-level sdram command driver: selects, ras/cas/we, data mask,
 separate address bit ten, clock enable, release of pins on host grant.
 assumes: an upstream sequencer presents one command per cmd_valid pulse with
 its address; host bus request arrives from a pin.
*/
// Functional notes
// - assert one decoded bank select per sdram command to region 01.
// - only the bus master drives the selects; others leave them undriven.
// - ras low in the cycle a row address is driven.
// - cas low in the cycle a column address is driven.
// - other commands encoded on ras, cas, we per sdram truth table.
// - while cas active, we low means write, high means read.
// - data mask high tristates dq; valid only while cas asserted.
// - data mask inactive on reads, used to mask writes only.
// - separate address bit ten pin lets refresh run beside other traffic.
// - clock enable controls self-refresh and power-down entry and exit.
// - on host grant clock enable held high, or low if self-refreshing.
// - on host grant enter self-refresh and release all command pins; data mask and separate address bit ten have no enable and stay driven.
`timescale 1ns/1ps
`include "sdram_pin_regs.vh"
module sdram_command_pins #(
	parameter EXIT_CYCLES = `LP_EXIT_CYC
) (
	// clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// arbitration
	input wire bus_master,
	input wire host_bus_request,
	output reg host_bus_grant,
	// command request
	input wire cmd_valid,
	input wire [2:0] cmd_code,
	input wire [31:0] cmd_addr,
	input wire cmd_reserved,
	input wire cmd_mask,
	input wire lp_exit,
	output wire cmd_ready,
	// sdram pins
	output reg [3:0] memory_bank_selects_n,
	output wire [3:0] memory_bank_selects_oe,
	output reg ras_n,
	output reg cas_n,
	output reg memory_write_strobe_n,
	output wire cmd_pins_oe,
	output reg low_word_data_mask,
	output reg refresh_address_bit_ten,
	output reg memory_clock_enable,
	output wire memory_clock_enable_oe,
	output reg [12:0] mem_addr,
	output wire mem_addr_oe,
	output reg cke_pull_high,
	output reg cke_pull_low
);
	localparam ST_IDLE = 4'h1;
	localparam ST_SELF = 4'h2;
	localparam ST_DOWN = 4'h4;
	localparam ST_HOST = 4'h8;

	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg [7:0] exit_cnt_reg;
	reg self_ref_reg;
	reg release_reg;
	wire hbr_sync;
	wire in_region;
	wire [3:0] bank_onehot;
	wire issue;
	reg [2:0] pins_next;

	pin_sync #(.WIDTH(1)) u_hbr_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.async_in(host_bus_request),
		.sync_out(hbr_sync)
	);

	bank_decode u_decode (
		.addr(cmd_addr),
		.reserved(cmd_reserved),
		.in_region(in_region),
		.bank_onehot(bank_onehot)
	);

	// commands only while idle, master, no host request pending and exit time done
	assign cmd_ready = (state_reg == ST_IDLE) && bus_master && !hbr_sync &&
		(exit_cnt_reg == 8'h00);
	assign issue = cmd_valid && cmd_ready && in_region;

	// pins float unless master and not handed to host; kept one cycle after entry
	// so the self-refresh command still reaches the memory
	assign cmd_pins_oe = bus_master && !release_reg;
	assign memory_bank_selects_oe = {4{cmd_pins_oe}};
	assign mem_addr_oe = cmd_pins_oe;
	assign memory_clock_enable_oe = cmd_pins_oe;

	always @* begin
		case (cmd_code)
		`CMD_READ: pins_next = `PINS_READ;
		`CMD_WRITE: pins_next = `PINS_WRITE;
		`CMD_ACTIVE: pins_next = `PINS_ACTIVE;
		`CMD_PRECHARGE: pins_next = `PINS_PRECHARGE;
		`CMD_REFRESH: pins_next = `PINS_REFRESH;
		`CMD_MODE: pins_next = `PINS_MODE;
		`CMD_SELF_REFRESH: pins_next = `PINS_REFRESH;
		default: pins_next = `PINS_NOP;
		endcase
	end

	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE: begin
			if (bus_master && hbr_sync)
				state_next = ST_HOST;
			else if (issue && cmd_code == `CMD_SELF_REFRESH)
				state_next = ST_SELF;
			else if (issue && cmd_code == `CMD_POWER_DOWN)
				state_next = ST_DOWN;
		end
		ST_SELF: begin
			if (bus_master && hbr_sync)
				state_next = ST_HOST;
			else if (lp_exit)
				state_next = ST_IDLE;
		end
		ST_DOWN: begin
			if (bus_master && hbr_sync)
				state_next = ST_HOST;
			else if (lp_exit)
				state_next = ST_IDLE;
		end
		ST_HOST: begin
			if (!hbr_sync)
				state_next = ST_IDLE;
		end
		default: state_next = ST_IDLE;
		endcase
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			exit_cnt_reg <= 8'h00;
			self_ref_reg <= 1'b0;
			release_reg <= 1'b0;
			host_bus_grant <= 1'b0;
			memory_bank_selects_n <= 4'hF;
			ras_n <= 1'b1;
			cas_n <= 1'b1;
			memory_write_strobe_n <= 1'b1;
			low_word_data_mask <= 1'b0;
			refresh_address_bit_ten <= 1'b0;
			memory_clock_enable <= 1'b1;
			mem_addr <= 13'h0000;
			cke_pull_high <= 1'b0;
			cke_pull_low <= 1'b0;
		end else begin
			state_reg <= state_next;
			// default is nop: selects off, strobes high
			memory_bank_selects_n <= 4'hF;
			ras_n <= 1'b1;
			cas_n <= 1'b1;
			memory_write_strobe_n <= 1'b1;
			low_word_data_mask <= 1'b0;
			if (issue && cmd_code != `CMD_POWER_DOWN) begin
				memory_bank_selects_n <= ~bank_onehot;
				{ras_n, cas_n, memory_write_strobe_n} <= pins_next;
				// mask only meaningful with cas, never on reads
				low_word_data_mask <= (cmd_code == `CMD_WRITE) && cmd_mask;
				mem_addr <= cmd_addr[14:2];
				// a10: auto precharge / all banks, also driven on the shared address lines as mem_addr bit 10
				refresh_address_bit_ten <= cmd_addr[12];
			end
			// hand-over: self-refresh entry on grant, pulls pick the resting cke level
			if (state_next == ST_HOST && state_reg != ST_HOST) begin
				if (state_reg != ST_SELF && self_ref_reg == 1'b0) begin
					memory_bank_selects_n <= 4'h0;
					{ras_n, cas_n, memory_write_strobe_n} <= `PINS_REFRESH;
				end
				self_ref_reg <= 1'b1;
				memory_clock_enable <= 1'b0;
			end else if (state_next == ST_SELF || state_next == ST_DOWN) begin
				memory_clock_enable <= 1'b0;
				self_ref_reg <= (state_next == ST_SELF);
			end else if (state_next == ST_IDLE && state_reg != ST_IDLE) begin
				memory_clock_enable <= 1'b1;
				self_ref_reg <= 1'b0;
				exit_cnt_reg <= EXIT_CYCLES[7:0];
			end else if (exit_cnt_reg != 8'h00) begin
				exit_cnt_reg <= exit_cnt_reg - 8'h01;
			end
			release_reg <= (state_next == ST_HOST) && (state_reg == ST_HOST);
			host_bus_grant <= (state_next == ST_HOST) && (state_reg == ST_HOST);
			// pull-up unless self-refresh was entered, then pull-down
			cke_pull_high <= bus_master && !(self_ref_reg || state_next == ST_SELF ||
				state_next == ST_HOST);
			cke_pull_low <= bus_master && (self_ref_reg || state_next == ST_SELF ||
				state_next == ST_HOST);
		end
	end
endmodule // sdram_command_pins

// file: dv/sdram_far_model.sv
/* far-side sdram model: logs commands, resolves the cke wire.
 assumes: pins of sdram_command_pins. */
`timescale 1ns/1ps
module sdram_far_model (
	// pins
	input wire ref_clk,
	input wire [3:0] sel_n,
	input wire [2:0] pins,
	input wire pins_oe,
	input wire cke,
	input wire cke_oe,
	input wire pull_hi,
	input wire pull_lo,
	// seen
	output wire cke_wire,
	output reg [2:0] last_cmd
);
	reg flip = 1'b0;
	// no driver, no pull: toggle so no stale level
	assign cke_wire = cke_oe ? cke : pull_lo ? 1'b0 : pull_hi ? 1'b1 : flip;
	always @(posedge ref_clk) begin
		flip <= ~flip;
		if (pins_oe && sel_n != 4'hF) begin
			last_cmd <= pins;
		end
	end
endmodule // sdram_far_model

// file: dv/sdram_pins_properties.sv
/* checker: pin rules of sdram_command_pins.
 assumes: bound to each instance. */
`timescale 1ns/1ps
module sdram_pins_props #(
	parameter EXIT_CYCLES = 2
) (
	// inputs
	input wire ref_clk,
	input wire sys_rst,
	input wire bus_master,
	input wire host_bus_request,
	input wire cmd_valid,
	input wire [2:0] cmd_code,
	input wire [31:0] cmd_addr,
	input wire cmd_reserved,
	input wire cmd_mask,
	// outputs
	input wire host_bus_grant,
	input wire cmd_ready,
	input wire [3:0] memory_bank_selects_n,
	input wire [3:0] memory_bank_selects_oe,
	input wire ras_n,
	input wire cas_n,
	input wire memory_write_strobe_n,
	input wire cmd_pins_oe,
	input wire low_word_data_mask,
	input wire refresh_address_bit_ten,
	input wire memory_clock_enable_oe,
	input wire cke_pull_low
);
	wire [2:0] pins = {ras_n, cas_n, memory_write_strobe_n};
	wire take = cmd_valid && cmd_ready;
	wire go = take && cmd_addr[31:30] == 2'h1 && !cmd_reserved;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	AST_WR: assert property (go && cmd_code == 3'h1 |=>
		pins == 3'h4 && low_word_data_mask == $past(cmd_mask)) else $error("bad write");
	AST_RD: assert property (go && cmd_code == 3'h0 |=>
		pins == 3'h5 && !low_word_data_mask) else $error("bad read");
	AST_ACT: assert property (go && cmd_code == 3'h2 |=> pins == 3'h3)
		else $error("bad active");
	AST_SEL: assert property (go && cmd_code < 3'h6 |=>
		memory_bank_selects_n == ~(4'h1 << $past(cmd_addr[29:28]))) else $error("bad select");
	AST_OUT: assert property (take && cmd_addr[31:30] != 2'h1 |=>
		pins == 3'h7 && memory_bank_selects_n == 4'hF) else $error("select off region");
	AST_PRE: assert property (go && cmd_code == 3'h3 |=>
		pins == 3'h2 && refresh_address_bit_ten == $past(cmd_addr[12])) else $error("bad pre");
	AST_MASK: assert property (low_word_data_mask |-> !cas_n && !memory_write_strobe_n)
		else $error("mask off write");
	AST_REL: assert property (host_bus_grant |-> !cmd_pins_oe && !memory_clock_enable_oe
		&& memory_bank_selects_oe == 4'h0 && cke_pull_low) else $error("pins kept");
	AST_SLV: assert property (!bus_master |-> memory_bank_selects_oe == 4'h0)
		else $error("slave drives");
	AST_GNT: assert property ($rose(host_bus_request) && bus_master |->
		##[1:6] host_bus_grant) else $error("no grant");
	cover property (go && cmd_code == 3'h1);
	cover property (go && cmd_code == 3'h6);
	cover property (host_bus_grant);
endmodule // sdram_pins_props
bind sdram_command_pins sdram_pins_props #(.EXIT_CYCLES(EXIT_CYCLES)) i_props (.*);

// file: dv/tb_sdram_command_pins.sv
/* bench for sdram_command_pins with far-side model.
 assumes: model and checker compiled first. */
`timescale 1ns/1ps
module tb_sdram_command_pins;
	reg ref_clk = 1'b0;
	reg sys_rst = 1'b1;
	reg bus_master = 1'b1;
	reg host_bus_request = 1'b0;
	reg cmd_valid = 1'b0;
	reg cmd_reserved = 1'b0;
	reg cmd_mask = 1'b0;
	reg lp_exit = 1'b0;
	reg [2:0] cmd_code = 3'h0;
	reg [31:0] cmd_addr = 32'h0;
	wire host_bus_grant, cmd_ready, ras_n, cas_n, memory_write_strobe_n, cmd_pins_oe;
	wire low_word_data_mask, refresh_address_bit_ten, memory_clock_enable, mem_addr_oe;
	wire memory_clock_enable_oe, cke_pull_high, cke_pull_low, cke_wire;
	wire [3:0] memory_bank_selects_n, memory_bank_selects_oe;
	wire [12:0] mem_addr;
	wire [2:0] last_cmd;
	wire [2:0] pins = {ras_n, cas_n, memory_write_strobe_n};
	wire [6:0] idle = {memory_bank_selects_n, pins};
	integer fails = 0;
	integer num_checks = 0;
	integer i;
	sdram_command_pins #(.EXIT_CYCLES(2)) i_sdram_command_pins (.*);
	sdram_far_model i_sdram_far_model (.ref_clk(ref_clk), .sel_n(memory_bank_selects_n),
		.pins(pins), .pins_oe(cmd_pins_oe), .cke(memory_clock_enable),
		.cke_oe(memory_clock_enable_oe), .pull_hi(cke_pull_high), .pull_lo(cke_pull_low),
		.cke_wire(cke_wire), .last_cmd(last_cmd));
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	task chk(input string nm, input [7:0] e, input [7:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("FAIL %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d fails %0d", num_checks, fails);
			if (fails == 0 && num_checks > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask
	// bounded wait, sampled off the edge
	task wait_ready;
		integer n;
		begin
			n = 0;
			@(negedge ref_clk);
			while (!cmd_ready && n < 40) begin
				n = n + 1;
				@(negedge ref_clk);
			end
			chk("ready", 8'h1, cmd_ready);
		end
	endtask
	task send(input [2:0] c, input [31:0] a, input m, input r);
		begin
			@(posedge ref_clk);
			cmd_valid <= 1'b1;
			cmd_code <= c;
			cmd_addr <= a;
			cmd_mask <= m;
			cmd_reserved <= r;
			wait_ready;
			@(posedge ref_clk);
			cmd_valid <= 1'b0;
			@(negedge ref_clk);
		end
	endtask
	task wake;
		begin
			@(posedge ref_clk);
			lp_exit <= 1'b1;
			wait_ready;
			@(posedge ref_clk);
			lp_exit <= 1'b0;
			chk("wake", 8'h1, memory_clock_enable);
		end
	endtask
	task t_rw;
		begin
			send(3'h1, 32'h6000_1000, 1'b1, 1'b0);
			chk("wr", 8'h5C, {memory_bank_selects_n, pins});
			chk("mask", 8'h1, low_word_data_mask);
			chk("addr", 8'h20, mem_addr[12:5]);
			send(3'h0, 32'h7000_0000, 1'b1, 1'b0);
			chk("rd", 8'h7A, {memory_bank_selects_n, pins, low_word_data_mask});
			@(negedge ref_clk);
			chk("nop", 8'h7F, idle);
			chk("model", 8'h5, last_cmd);
		end
	endtask
	task t_codes;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				send(3'h2 + i[2:0], 32'h4000_1000, 1'b0, 1'b0);
				chk("cmd", 3'h3 - i[2:0], pins);
				chk("a10", 8'h1, refresh_address_bit_ten);
			end
			send(3'h1, 32'h8000_0000, 1'b0, 1'b0);
			chk("out", 8'h7F, idle);
			send(3'h1, 32'h4000_0000, 1'b0, 1'b1);
			chk("rsv", 8'h7F, idle);
		end
	endtask
	task t_low;
		begin
			send(3'h6, 32'h4000_0000, 1'b0, 1'b0);
			chk("sr", 8'h2, {pins, memory_clock_enable});
			chk("busy", 8'h0, cmd_ready);
			wake;
			send(3'h7, 32'h4000_0000, 1'b0, 1'b0);
			chk("pd", 8'hE, {pins, memory_clock_enable});
			wake;
		end
	endtask
	task t_host;
		begin
			send(3'h0, 32'h4000_0000, 1'b0, 1'b0);
			chk("pull", 8'h2, {cke_pull_high, cke_pull_low});
			@(posedge ref_clk);
			host_bus_request <= 1'b1;
			for (i = 0; i < 20 && host_bus_grant !== 1'b1; i = i + 1) @(negedge ref_clk);
			chk("rel", 8'h0, {cmd_pins_oe, memory_bank_selects_oe, memory_clock_enable_oe,
				mem_addr_oe});
			chk("srf", 8'h1, last_cmd);
			chk("cke", 8'h0, {cke_wire, cmd_ready});
			@(posedge ref_clk);
			host_bus_request <= 1'b0;
			wait_ready;
			chk("cke", 8'h1, cke_wire);
		end
	endtask
	task t_slave;
		begin
			@(posedge ref_clk);
			bus_master <= 1'b0;
			@(negedge ref_clk);
			chk("slv", 8'h0, {memory_bank_selects_oe, cmd_ready});
			@(posedge ref_clk);
			bus_master <= 1'b1;
			wait_ready;
		end
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_rw;
		t_codes;
		t_low;
		t_host;
		t_slave;
		give_verdict;
	end
	// run needs well under 2500 cycles
	initial begin
		#100000;
		fails = fails + 1;
		give_verdict;
	end
endmodule // tb_sdram_command_pins
